// ==== hw/dcsj_pkg.sv ====
package dcsj_pkg;
  localparam int unsigned DCSJ_N_DI = 8;
  localparam logic [7:0] DCSJ_FN_NONE = 8'h00;
  localparam logic [7:0] DCSJ_FN_EMG = 8'h15;
  localparam logic [7:0] DCSJ_FN_RLIM = 8'h16;
  localparam logic [7:0] DCSJ_FN_FLIM = 8'h17;
  localparam logic [7:0] DCSJ_FN_ENERGIZE = 8'h65;
  localparam logic [7:0] DCSJ_FN_CLEAR = 8'h66;
  localparam logic [7:0] DCSJ_FN_TRIGGER = 8'h6C;
  localparam logic [7:0] DCSJ_FN_POS0 = 8'h6F;
  localparam logic [7:0] DCSJ_FN_TLIM = 8'h6D;
  localparam logic [7:0] DCSJ_FN_SEL_LO = 8'h72;
  localparam logic [7:0] DCSJ_FN_SEL_HI = 8'h73;
  localparam logic [7:0] DCSJ_FN_DI6_RST = 8'h16;
  localparam logic [7:0] DCSJ_FN_DI7_RST = 8'h17;
  localparam logic [7:0] DCSJ_FN_DI8_RST = 8'h15;
  localparam logic [7:0] DCSJ_FN_OTHER_RST = 8'h00;
  localparam logic [7:0] DCSJ_MODE_POS = 8'h01;
  localparam logic [7:0] DCSJ_MODE_SPEED = 8'h02;
  localparam logic [7:0] DCSJ_MODE_RST = 8'h02;
  localparam int DCSJ_PRESET_MIN = -60000;
  localparam int DCSJ_PRESET_MAX = 60000;
  localparam logic [15:0] DCSJ_JOG_RST = 16'h0014;
  localparam logic [15:0] DCSJ_JOG_MAX = 16'h1388;
  localparam int DCSJ_JOG_TO_TENTHS = 10;
  localparam int DCSJ_DIGITS = 4;
  localparam int DCSJ_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    DCSJ_ST_RUN = 2'b00,
    DCSJ_ST_EDIT = 2'b01,
    DCSJ_ST_JOG = 2'b11
  } dcsj_state_t;

  typedef struct packed {
    logic up;
    logic down;
    logic shift;
    logic set;
    logic mode;
  } dcsj_keys_t;

  typedef struct packed {
    logic emg;
    logic rlim;
    logic flim;
  } dcsj_fault_t;

  typedef struct packed {
    logic energize;
    logic tlim;
    logic sel_lo;
    logic sel_hi;
    logic clear;
    logic trigger;
    logic [5:0] pos_sel;
    dcsj_fault_t fault_req;
  } dcsj_func_t;
endpackage : dcsj_pkg

// ==== hw/dcsj_sync.sv ====
module dcsj_sync
  import dcsj_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
  } dcsj_sync_st_t;

  dcsj_sync_st_t st_r;
  dcsj_sync_st_t st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("dcsj_sync width must be positive");
  end

  // level changes only once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s2[i];
      end
    end
    st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;
  assign o_rise = st_r.rise;
endmodule : dcsj_sync

// ==== hw/dcsj_func_map.sv ====
module dcsj_func_map
  import dcsj_pkg::*;
#(
  parameter int N_DI = DCSJ_N_DI
) (
  input wire logic [N_DI-1:0] i_level,
  input wire logic [N_DI-1:0] i_rise,
  input wire logic [N_DI*8-1:0] i_map,
  output dcsj_func_t o_func
);
  logic [N_DI-1:0] hit_en, hit_tl, hit_lo, hit_hi, hit_clr, hit_trg;
  logic [N_DI-1:0] hit_emg, hit_rl, hit_fl;
  logic [N_DI-1:0] hit_p0, hit_p1, hit_p2, hit_p3, hit_p4, hit_p5;

  if (N_DI < 1 || N_DI > 16) begin : g_bad_n_di
    $error("dcsj_func_map input count bad");
  end

  // code zero matches nothing, so the input is ignored
  for (genvar g = 0; g < N_DI; g++) begin : g_di
    logic [7:0] code;
    assign code = i_map[g*8 +: 8];
    assign hit_en[g] = (code == DCSJ_FN_ENERGIZE) && i_level[g];
    assign hit_tl[g] = (code == DCSJ_FN_TLIM) && i_level[g];
    assign hit_lo[g] = (code == DCSJ_FN_SEL_LO) && i_level[g];
    assign hit_hi[g] = (code == DCSJ_FN_SEL_HI) && i_level[g];
    assign hit_clr[g] = (code == DCSJ_FN_CLEAR) && i_rise[g];
    assign hit_trg[g] = (code == DCSJ_FN_TRIGGER) && i_rise[g];
    assign hit_emg[g] = (code == DCSJ_FN_EMG) && !i_level[g];
    assign hit_rl[g] = (code == DCSJ_FN_RLIM) && !i_level[g];
    assign hit_fl[g] = (code == DCSJ_FN_FLIM) && !i_level[g];
    assign hit_p0[g] = (code == DCSJ_FN_POS0) && i_level[g];
    assign hit_p1[g] = (code == DCSJ_FN_POS0 + 8'h01) && i_level[g];
    assign hit_p2[g] = (code == DCSJ_FN_POS0 + 8'h02) && i_level[g];
    assign hit_p3[g] = (code == DCSJ_FN_POS0 + 8'h03) && i_level[g];
    assign hit_p4[g] = (code == DCSJ_FN_POS0 + 8'h04) && i_level[g];
    assign hit_p5[g] = (code == DCSJ_FN_POS0 + 8'h05) && i_level[g];
  end

  always_comb begin
    o_func.energize = |hit_en;
    o_func.tlim = |hit_tl;
    o_func.sel_lo = |hit_lo;
    o_func.sel_hi = |hit_hi;
    o_func.clear = |hit_clr;
    o_func.trigger = |hit_trg;
    o_func.pos_sel = {|hit_p5, |hit_p4, |hit_p3, |hit_p2, |hit_p1, |hit_p0};
    o_func.fault_req.emg = |hit_emg;
    o_func.fault_req.rlim = |hit_rl;
    o_func.fault_req.flim = |hit_fl;
  end
endmodule : dcsj_func_map

// ==== hw/dcsj_top.sv ====
// Behaviour
// - speed select bits pick analog or presets
// - presets clamped to plus/minus sixty thousand
// - preset counts are 0.1 r/min steps
// - input functions chosen by numeric code
// - code zero inputs are ignored
// - inactive emergency halt input raises fault
// - inactive reverse limit input raises fault
// - inactive forward limit input raises fault
// - default map puts limits, halt on 6-8
// - restart or clear input clears alarms
// - mode selector applies only after restart
// - software enable means drive enabled
// - SET confirms jog speed, enters jog
// - UP/DOWN edit, SHIFT moves digit
// - UP held runs counterclockwise at jog speed
// - DOWN held runs clockwise at jog speed
// - MODE key leaves jog mode
// - jog speed resets to 20 r/min
// - six bits pick position, trigger acts
module dcsj_top
  import dcsj_pkg::*;
#(
  parameter int N_DI = DCSJ_N_DI
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [N_DI-1:0] i_di,
  input wire logic [4:0] i_keys,
  input wire logic [N_DI*8-1:0] i_input_function_map,
  input wire logic [7:0] i_control_mode_selector,
  input wire logic [16:0] i_speed_preset_one,
  input wire logic [16:0] i_speed_preset_two,
  input wire logic [16:0] i_speed_preset_three,
  input wire logic i_software_enable_setting,
  input wire logic [17:0] i_analog_cmd,
  output logic [17:0] o_speed_cmd,
  output logic o_drive_active,
  output logic o_torque_limit_enable,
  output logic o_speed_mode,
  output logic o_jog_mode,
  output logic o_jog_edit,
  output logic [15:0] o_jog_speed,
  output logic [1:0] o_jog_digit,
  output dcsj_fault_t o_faults,
  output logic [5:0] o_position_index,
  output logic o_position_start
);
  localparam logic [15:0] JOG_STEP [DCSJ_DIGITS] =
    '{16'h0001, 16'h000A, 16'h0064, 16'h03E8};

  typedef struct packed {
    dcsj_state_t st;
    logic [7:0] mode;
    logic mode_taken;
    logic [15:0] jog;
    logic [1:0] digit;
    dcsj_fault_t faults;
    logic [17:0] cmd;
    logic active;
    logic tlim;
    logic [5:0] pos_idx;
    logic pos_go;
  } dcsj_top_st_t;

  dcsj_top_st_t st_r;
  dcsj_top_st_t st_nxt;
  logic [N_DI-1:0] di_lvl, di_rise;
  logic [4:0] key_lvl, key_rise;
  dcsj_keys_t kl, kr;
  dcsj_func_t fn;
  logic [16:0] preset_sel;
  logic signed [17:0] preset_clamped;
  logic [15:0] jog_step;
  logic [17:0] jog_tenths;
  logic [17:0] speed_ref;
  logic enabled;

  if (N_DI < 6 || N_DI > 16) begin : g_bad_n_di
    $error("dcsj_top needs 6 to 16 inputs");
  end

  dcsj_sync #(.WIDTH(N_DI)) u_di_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_di),
    .o_level(di_lvl),
    .o_rise(di_rise)
  );

  dcsj_sync #(.WIDTH(5)) u_key_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_keys),
    .o_level(key_lvl),
    .o_rise(key_rise)
  );

  dcsj_func_map #(.N_DI(N_DI)) u_map (
    .i_level(di_lvl),
    .i_rise(di_rise),
    .i_map(i_input_function_map),
    .o_func(fn)
  );

  assign kl = dcsj_keys_t'(key_lvl);
  assign kr = dcsj_keys_t'(key_rise);

  // preset choice and clamp
  always_comb begin
    case ({fn.sel_hi, fn.sel_lo})
      2'b01: preset_sel = i_speed_preset_one;
      2'b10: preset_sel = i_speed_preset_two;
      2'b11: preset_sel = i_speed_preset_three;
      default: preset_sel = '0;
    endcase
    preset_clamped = 18'(signed'(preset_sel));
    if (preset_clamped > 18'(DCSJ_PRESET_MAX)) begin
      preset_clamped = 18'(DCSJ_PRESET_MAX);
    end else if (preset_clamped < 18'(DCSJ_PRESET_MIN)) begin
      preset_clamped = 18'(DCSJ_PRESET_MIN);
    end
  end

  // jog speed in r/min converted to 0.1 r/min counts
  assign jog_tenths = 18'(st_r.jog * 16'(DCSJ_JOG_TO_TENTHS));
  assign jog_step = JOG_STEP[st_r.digit];
  // preset passes through unscaled: output unit is 0.1 r/min
  assign speed_ref = ({fn.sel_hi, fn.sel_lo} == 2'b00) ? i_analog_cmd
                   : 18'(preset_clamped);
  assign enabled = i_software_enable_setting || fn.energize;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pos_go = 1'b0;
    // mode selector captured once after restart
    if (!st_r.mode_taken) begin
      st_nxt.mode = i_control_mode_selector;
      st_nxt.mode_taken = 1'b1;
    end
    // clear first, fault requests win over clear
    if (fn.clear) begin
      st_nxt.faults = '0;
    end
    st_nxt.faults = st_nxt.faults | fn.fault_req;
    case (st_r.st)
      DCSJ_ST_RUN: begin
        if (kr.set) begin
          st_nxt.st = DCSJ_ST_EDIT;
          st_nxt.digit = '0;
        end
      end
      DCSJ_ST_EDIT: begin
        if (kr.mode) begin
          st_nxt.st = DCSJ_ST_RUN;
        end else if (kr.set) begin
          st_nxt.st = DCSJ_ST_JOG;
        end else if (kr.up) begin
          if (st_r.jog <= DCSJ_JOG_MAX - jog_step) begin
            st_nxt.jog = st_r.jog + jog_step;
          end
        end else if (kr.down) begin
          if (st_r.jog >= jog_step) begin
            st_nxt.jog = st_r.jog - jog_step;
          end
        end else if (kr.shift) begin
          st_nxt.digit = st_r.digit + 2'd1;
        end
      end
      DCSJ_ST_JOG: begin
        if (kr.mode) begin
          st_nxt.st = DCSJ_ST_RUN;
        end
      end
      default: st_nxt.st = DCSJ_ST_RUN;
    endcase
    st_nxt.active = enabled && (st_nxt.faults == '0);
    st_nxt.tlim = fn.tlim;
    if (!st_nxt.active) begin
      st_nxt.cmd = '0;
    end else if (st_r.st == DCSJ_ST_JOG) begin
      if (kl.up && !kl.down) begin
        st_nxt.cmd = jog_tenths;
      end else if (kl.down && !kl.up) begin
        st_nxt.cmd = 18'(-signed'(jog_tenths));
      end else begin
        st_nxt.cmd = '0;
      end
    end else if (st_r.mode_taken && st_r.mode == DCSJ_MODE_SPEED) begin
      st_nxt.cmd = speed_ref;
    end else begin
      st_nxt.cmd = '0;
    end
    if (st_r.mode == DCSJ_MODE_POS && st_nxt.active && fn.trigger) begin
      st_nxt.pos_idx = fn.pos_sel;
      st_nxt.pos_go = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{st: DCSJ_ST_RUN, mode: DCSJ_MODE_RST, mode_taken: 1'b0,
                jog: DCSJ_JOG_RST, digit: 2'd0, faults: '0,
                cmd: '0, active: 1'b0, tlim: 1'b0, pos_idx: '0,
                pos_go: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_speed_cmd = st_r.cmd;
  assign o_drive_active = st_r.active;
  assign o_torque_limit_enable = st_r.tlim;
  assign o_speed_mode = (st_r.mode == DCSJ_MODE_SPEED);
  assign o_jog_mode = (st_r.st == DCSJ_ST_JOG);
  assign o_jog_edit = (st_r.st == DCSJ_ST_EDIT);
  assign o_jog_speed = st_r.jog;
  assign o_jog_digit = st_r.digit;
  assign o_faults = st_r.faults;
  assign o_position_index = st_r.pos_idx;
  assign o_position_start = st_r.pos_go;

  fault_latch_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.faults.emg && !fn.clear) |=> st_r.faults.emg
  ) else $error("fault dropped without clear");

  fault_inhibit_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.faults != '0) |-> st_r.cmd == '0
  ) else $error("drive runs with fault latched");

  emg_raise_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    fn.fault_req.emg |=> st_r.faults.emg
  ) else $error("emergency fault not raised");

  rlim_raise_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    fn.fault_req.rlim |=> st_r.faults.rlim
  ) else $error("reverse limit fault not raised");

  flim_raise_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    fn.fault_req.flim |=> st_r.faults.flim
  ) else $error("forward limit fault not raised");

  alarm_clear_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (fn.clear && fn.fault_req == '0) |=> st_r.faults == '0
  ) else $error("alarms not cleared");

  mode_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    st_r.mode_taken |=> $stable(st_r.mode)
  ) else $error("mode changed without restart");

  analog_pass_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.mode_taken && st_r.mode == DCSJ_MODE_SPEED && st_nxt.active &&
      st_r.st != DCSJ_ST_JOG && {fn.sel_hi, fn.sel_lo} == 2'b00)
      |=> st_r.cmd == $past(i_analog_cmd)
  ) else $error("analog command not passed");

  preset_range_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.mode_taken && st_r.mode == DCSJ_MODE_SPEED && st_nxt.active &&
      st_r.st != DCSJ_ST_JOG && {fn.sel_hi, fn.sel_lo} != 2'b00)
      |=> ($signed(st_r.cmd) <= DCSJ_PRESET_MAX &&
        $signed(st_r.cmd) >= DCSJ_PRESET_MIN)
  ) else $error("preset command out of range");

  jog_enter_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_EDIT && kr.set && !kr.mode)
      |=> st_r.st == DCSJ_ST_JOG
  ) else $error("SET did not enter jog");

  jog_exit_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_JOG && kr.mode) |=> st_r.st == DCSJ_ST_RUN
  ) else $error("MODE did not leave jog");

  digit_step_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_EDIT && kr.shift && !kr.mode && !kr.set &&
      !kr.up && !kr.down) |=> st_r.digit == $past(st_r.digit) + 2'd1
  ) else $error("SHIFT did not move digit");

  jog_ccw_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_JOG && st_nxt.active && kl.up && !kl.down)
      |=> st_r.cmd == $past(jog_tenths)
  ) else $error("jog up speed wrong");

  jog_cw_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_JOG && st_nxt.active && kl.down && !kl.up)
      |=> st_r.cmd == 18'(-$past(jog_tenths))
  ) else $error("jog down speed wrong");

  jog_stop_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r.st == DCSJ_ST_JOG && !kl.up && !kl.down) |=> st_r.cmd == '0
  ) else $error("jog runs with no key");

  enable_sw_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_software_enable_setting && st_nxt.faults == '0)
      |=> st_r.active
  ) else $error("software enable ignored");

  pos_start_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    st_r.pos_go |-> (st_r.mode == DCSJ_MODE_POS && st_r.active)
  ) else $error("position start outside position mode");

  pos_pulse_a: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    st_r.pos_go |=> !st_r.pos_go
  ) else $error("position start longer than one cycle");
endmodule : dcsj_top

// ==== tb/dcsj_ctrl_model.sv ====
module dcsj_ctrl_model
  import dcsj_pkg::*;
(
  input wire logic i_core_clk,
  output logic [7:0] o_di,
  output logic [4:0] o_keys,
  output logic [63:0] o_map
);
  timeunit 1ns;
  timeprecision 100ps;

  // default map after power-up
  initial begin
    o_di = 8'h00;
    o_keys = 5'h00;
    o_map = {DCSJ_FN_DI8_RST, DCSJ_FN_DI7_RST, DCSJ_FN_DI6_RST, 40'h00};
  end

  task automatic put_di(input logic [7:0] v);
    @(posedge i_core_clk);
    #2;
    o_di = v;
  endtask : put_di

  // set one input's function code
  task automatic put_map(input int g, input logic [7:0] code);
    @(posedge i_core_clk);
    #2;
    o_map[g*8+:8] = code;
  endtask : put_map

  task automatic hold_keys(input logic [4:0] k);
    @(posedge i_core_clk);
    #2;
    o_keys = k;
  endtask : hold_keys

  task automatic tap_key(input logic [4:0] k);
    hold_keys(k);
    repeat (8) @(posedge i_core_clk);
    #2;
    o_keys = 5'h00;
    repeat (8) @(posedge i_core_clk);
    #2;
  endtask : tap_key

  // pulse on the alarm clear input
  task automatic tap_di(input int g);
    @(posedge i_core_clk);
    #2;
    o_di[g] = 1'b1;
    repeat (8) @(posedge i_core_clk);
    #2;
    o_di[g] = 1'b0;
    repeat (8) @(posedge i_core_clk);
    #2;
  endtask : tap_di
endmodule : dcsj_ctrl_model

// ==== tb/tb.sv ====
module tb
  import dcsj_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic nrst;
  logic [7:0] di;
  logic [4:0] keys;
  logic [63:0] fmap;
  logic [7:0] mode_sel;
  logic [16:0] p1;
  logic [16:0] p2;
  logic [16:0] p3;
  logic sw_en;
  logic [17:0] analog;
  logic [17:0] speed;
  logic active, tlim, smode, jmode, jedit, pstart;
  logic [15:0] jspeed;
  logic [1:0] jdigit;
  logic [5:0] pidx;
  dcsj_fault_t faults;
  int bad_count = 0;
  int n_tests = 0;

  always #12.5 core_clk = ~core_clk;

  dcsj_top u_dcsj_top (.i_core_clk(core_clk), .i_nrst(nrst), .i_di(di),
    .i_keys(keys), .i_input_function_map(fmap),
    .i_control_mode_selector(mode_sel), .i_speed_preset_one(p1),
    .i_speed_preset_two(p2), .i_speed_preset_three(p3),
    .i_software_enable_setting(sw_en), .i_analog_cmd(analog),
    .o_speed_cmd(speed), .o_drive_active(active),
    .o_torque_limit_enable(tlim), .o_speed_mode(smode), .o_jog_mode(jmode),
    .o_jog_edit(jedit), .o_jog_speed(jspeed), .o_jog_digit(jdigit),
    .o_faults(faults), .o_position_index(pidx), .o_position_start(pstart));
  dcsj_ctrl_model u_dcsj_ctrl_model (.i_core_clk(core_clk), .o_di(di),
    .o_keys(keys), .o_map(fmap));

  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  function automatic logic [17:0] exp_cmd(input logic [1:0] sel);
    logic [17:0] p;
    case (sel)
      2'h0: return analog;
      2'h1: p = {p1[16], p1};
      2'h2: p = {p2[16], p2};
      default: p = {p3[16], p3};
    endcase
    if ($signed(p) > DCSJ_PRESET_MAX) p = 18'(DCSJ_PRESET_MAX);
    if ($signed(p) < DCSJ_PRESET_MIN) p = 18'(DCSJ_PRESET_MIN);
    return p;
  endfunction : exp_cmd

  task automatic settle;
    repeat (8) @(posedge core_clk);
    #2;
  endtask : settle

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end

  // position inputs sit on every pin but trigger and clear
  function automatic int pos_pin(input int k);
    return (k == 0) ? 0 : (k < 3) ? k + 1 : k + 2;
  endfunction : pos_pin

  initial begin
    int g;
    int hits;
    logic [1:0] s;
    logic t;
    logic [5:0] v;
    logic [5:0] got;
    nrst = 1'b0;
    mode_sel = DCSJ_MODE_SPEED;
    p1 = 17'h00000;
    p2 = 17'h00000;
    p3 = 17'h00000;
    sw_en = 1'b0;
    analog = 18'h00000;
    got = 6'h00;
    void'($urandom(55199));
    repeat (8) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    settle();
    chk_val({15'h0000, faults}, 18'h00007);
    chk_val({2'h0, jspeed}, 18'h00014);
    chk_bit(smode, 1'b1);
    chk_bit(active, 1'b0);
    for (int k = 5; k < 8; k++) begin
      u_dcsj_ctrl_model.put_map(k, DCSJ_FN_NONE);
    end
    settle();
    chk_val({15'h0000, faults}, 18'h00007);
    u_dcsj_ctrl_model.put_map(4, DCSJ_FN_CLEAR);
    u_dcsj_ctrl_model.tap_di(4);
    chk_val({15'h0000, faults}, 18'h00000);
    u_dcsj_ctrl_model.put_map(0, DCSJ_FN_ENERGIZE);
    u_dcsj_ctrl_model.put_map(1, DCSJ_FN_TLIM);
    u_dcsj_ctrl_model.put_map(2, DCSJ_FN_SEL_LO);
    u_dcsj_ctrl_model.put_map(3, DCSJ_FN_SEL_HI);
    mode_sel = DCSJ_MODE_POS;
    for (int i = 0; i < 12; i++) begin
      p1 = 17'($urandom);
      p2 = 17'($urandom);
      p3 = 17'($urandom);
      analog = 18'($urandom);
      if (i == 0) p1 = 17'h0EA60;
      if (i == 1) p2 = 17'h10000;
      if (i == 2) p3 = 17'h0FFFF;
      if (i == 4) p1 = 17'h115A0;
      s = 2'((i + 1) % 4);
      t = 1'($urandom);
      u_dcsj_ctrl_model.put_di({4'h0, s, t, 1'b1});
      settle();
      chk_val(speed, exp_cmd(s));
      chk_bit(tlim, t);
      chk_bit(active, 1'b1);
      chk_bit(smode, 1'b1);
    end
    u_dcsj_ctrl_model.put_map(2, DCSJ_FN_NONE);
    u_dcsj_ctrl_model.put_di(8'h05);
    settle();
    chk_val(speed, analog);
    u_dcsj_ctrl_model.put_di(8'h00);
    sw_en = 1'b1;
    settle();
    chk_bit(active, 1'b1);
    sw_en = 1'b0;
    settle();
    chk_bit(active, 1'b0);
    for (int k = 0; k < 3; k++) begin
      g = 5 + $urandom_range(2);
      u_dcsj_ctrl_model.put_di(8'h01);
      u_dcsj_ctrl_model.put_map(g, 8'(DCSJ_FN_EMG + k));
      settle();
      chk_val({15'h0000, faults}, 18'h00004 >> k);
      chk_bit(active, 1'b0);
      chk_val(speed, 18'h00000);
      u_dcsj_ctrl_model.put_di(8'h01 | (8'h01 << g));
      settle();
      chk_val({15'h0000, faults}, 18'h00004 >> k);
      u_dcsj_ctrl_model.put_map(g, DCSJ_FN_NONE);
      u_dcsj_ctrl_model.tap_di(4);
      chk_val({15'h0000, faults}, 18'h00000);
    end
    u_dcsj_ctrl_model.put_di(8'h00);
    sw_en = 1'b1;
    u_dcsj_ctrl_model.tap_key(5'h02);
    chk_bit(jedit, 1'b1);
    u_dcsj_ctrl_model.tap_key(5'h10);
    chk_val({2'h0, jspeed}, 18'h00015);
    u_dcsj_ctrl_model.tap_key(5'h04);
    chk_val({16'h0000, jdigit}, 18'h00001);
    u_dcsj_ctrl_model.tap_key(5'h10);
    chk_val({2'h0, jspeed}, 18'h0001F);
    u_dcsj_ctrl_model.tap_key(5'h08);
    chk_val({2'h0, jspeed}, 18'h00015);
    u_dcsj_ctrl_model.tap_key(5'h02);
    chk_bit(jmode, 1'b1);
    chk_bit(jedit, 1'b0);
    u_dcsj_ctrl_model.hold_keys(5'h10);
    settle();
    chk_val(speed, 18'h000D2);
    u_dcsj_ctrl_model.hold_keys(5'h00);
    settle();
    chk_val(speed, 18'h00000);
    u_dcsj_ctrl_model.hold_keys(5'h08);
    settle();
    chk_val(speed, 18'h3FF2E);
    u_dcsj_ctrl_model.hold_keys(5'h00);
    settle();
    chk_val(speed, 18'h00000);
    u_dcsj_ctrl_model.tap_key(5'h01);
    chk_bit(jmode, 1'b0);
    // restart in mid-run: position mode now takes effect
    u_dcsj_ctrl_model.put_di(8'h00);
    nrst = 1'b0;
    repeat (4) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    settle();
    chk_bit(smode, 1'b0);
    chk_val({2'h0, jspeed}, 18'h00014);
    chk_bit(active, 1'b1);
    u_dcsj_ctrl_model.put_map(1, DCSJ_FN_TRIGGER);
    for (int k = 0; k < 6; k++) begin
      u_dcsj_ctrl_model.put_map(pos_pin(k), 8'(DCSJ_FN_POS0 + k));
    end
    for (int i = 0; i < 3; i++) begin
      v = 6'($urandom);
      if (i == 0) v = 6'h3F;
      u_dcsj_ctrl_model.put_di({v[5:3], 1'b0, v[2:1], 1'b0, v[0]});
      settle();
      chk_bit(pstart, 1'b0);
      chk_val(speed, 18'h00000);
      u_dcsj_ctrl_model.put_di({v[5:3], 1'b0, v[2:1], 1'b1, v[0]});
      hits = 0;
      repeat (8) begin
        @(posedge core_clk);
        #2;
        if (pstart === 1'b1) begin
          hits++;
          got = pidx;
        end
      end
      chk_val(18'(hits), 18'h00001);
      chk_val({12'h000, got}, {12'h000, v});
      chk_val({12'h000, pidx}, {12'h000, v});
    end
    wrap_up();
  end
endmodule : tb
